/* File: src/tmirq_params.svh */
// register offsets, bit positions and reset values of the timer interrupt block
`ifndef TMIRQ_PARAMS_SVH
`define TMIRQ_PARAMS_SVH
`define TMIRQ_OFS_MASK 8'h00
`define TMIRQ_OFS_EXT_MASK 8'h04
`define TMIRQ_OFS_FLAGS 8'h08
`define TMIRQ_OFS_EXT_FLAGS 8'h0c
`define TMIRQ_OFS_GLOBAL 8'h10
`define TMIRQ_OFS_IRQ_STATUS 8'h14
`define TMIRQ_OFS_IRQ_MASK 8'h18
`define TMIRQ_ADDR_LSB 2
`define TMIRQ_ADDR_MSB 7
`define TMIRQ_RST8 8'h00
`define TMIRQ_RST32 32'h0000_0000
`define TMIRQ_BIT_T1_OVF 7
`define TMIRQ_BIT_T1_CMPA 6
`define TMIRQ_BIT_T1_CMPB 5
`define TMIRQ_BIT_T1_CAP 3
`define TMIRQ_BIT_T3_CAP 5
`define TMIRQ_BIT_T3_CMPA 4
`define TMIRQ_BIT_T3_CMPB 3
`define TMIRQ_BIT_T3_OVF 2
`define TMIRQ_T1_BITS 8'he8
`define TMIRQ_T3_BITS 8'h3c
`define TMIRQ_HTRANS_NONSEQ 2'b10
`define TMIRQ_HTRANS_SEQ 2'b11
`endif

/* File: src/tmirq_pkg.sv */
// types shared by the timer interrupt block
package tmirq_pkg;
  // event strobes for one 16-bit timer
  typedef struct packed {
    logic overflow;
    logic match_a;
    logic match_b;
    logic capture_edge;
    logic reached_top;
    logic capture_is_top;
    logic force_a;
    logic force_b;
  } tmirq_timer_ev_t;
  // interrupt vector acknowledge, one bit per source
  typedef struct packed {
    logic t1_ovf;
    logic t1_cmpa;
    logic t1_cmpb;
    logic t1_cap;
    logic t3_cap;
    logic t3_cmpa;
    logic t3_cmpb;
    logic t3_ovf;
  } tmirq_src_t;
endpackage

/* File: src/tmirq_timer_flags.sv */
// set logic for the four flags of one 16-bit timer
`timescale 1ns/100ps
module tmirq_timer_flags
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // timer events
  input wire tmirq_pkg::tmirq_timer_ev_t ev,
  // set strobes: overflow, compare a, compare b, capture
  output logic [3:0] set_q
);
  import tmirq_pkg::*;
  logic match_a_q;
  logic match_b_q;

  // compare match registered so its flag sets one timer cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
    end
    else
    begin
      match_a_q <= ev.match_a;
      match_b_q <= ev.match_b;
    end
  end

  // force strobes are not wired in: they never set a match flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      set_q <= 4'h0;
    else
    begin
      set_q[3] <= ev.overflow;
      set_q[2] <= match_a_q;
      set_q[1] <= match_b_q;
      set_q[0] <= ev.capture_is_top ? ev.reached_top : ev.capture_edge;
    end
  end
endmodule

/* File: src/tmirq_top.sv */
// timer 1 and timer 3 interrupt mask and flag registers with an ahb-lite slave
// ===========================================================================
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "tmirq_params.svh"
module tmirq_top
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // timer events, same clock domain
  input wire tmirq_pkg::tmirq_timer_ev_t t1_ev,
  input wire tmirq_pkg::tmirq_timer_ev_t t3_ev,
  // cpu core side
  input wire logic global_irq_en,
  input wire tmirq_pkg::tmirq_src_t vector_ack,
  output tmirq_pkg::tmirq_src_t irq_req,
  // summary interrupt
  output logic irq
);
  import tmirq_pkg::*;

  // ===========================================================================
  // state
  logic [7:0] timer_irq_mask_q;
  logic [7:0] ext_timer_irq_mask_q;
  logic [7:0] timer_irq_flags_q;
  logic [7:0] ext_timer_irq_flags_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [3:0] t1_set;
  logic [3:0] t3_set;
  logic [7:0] set_main;
  logic [7:0] set_ext;
  logic [7:0] ack_main;
  logic [7:0] ack_ext;
  logic wr_pend_q;
  logic [5:0] wr_idx_q;
  logic [5:0] addr_idx;
  logic addr_ok;
  logic rd_take;
  logic wr_mask;
  logic wr_ext_mask;
  logic wr_flags;
  logic wr_ext_flags;
  logic wr_status;
  logic wr_irq_mask;
  logic [7:0] wdat;
  logic [7:0] w1c_main;
  logic [7:0] w1c_ext;
  logic [7:0] w1c_stat;
  logic [7:0] new_events;
  logic [7:0] rd_val;
  tmirq_src_t req_d;
  logic [7:0] flags_d;
  logic [7:0] ext_flags_d;
  logic [7:0] status_d;
  logic irq_d;

  // ===========================================================================
  // flag set engines, one per timer
  tmirq_timer_flags u_t1
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .ev(t1_ev),
    .set_q(t1_set)
  );

  tmirq_timer_flags u_t3
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .ev(t3_ev),
    .set_q(t3_set)
  );

  // map set strobes onto register bit positions
  always_comb
  begin
    set_main = `TMIRQ_RST8;
    set_ext = `TMIRQ_RST8;
    set_main[`TMIRQ_BIT_T1_OVF] = t1_set[3];
    set_main[`TMIRQ_BIT_T1_CMPA] = t1_set[2];
    set_main[`TMIRQ_BIT_T1_CMPB] = t1_set[1];
    set_main[`TMIRQ_BIT_T1_CAP] = t1_set[0];
    set_ext[`TMIRQ_BIT_T3_CAP] = t3_set[0];
    set_ext[`TMIRQ_BIT_T3_CMPA] = t3_set[2];
    set_ext[`TMIRQ_BIT_T3_CMPB] = t3_set[1];
    set_ext[`TMIRQ_BIT_T3_OVF] = t3_set[3];
  end

  // map vector acknowledges onto register bit positions
  always_comb
  begin
    ack_main = `TMIRQ_RST8;
    ack_ext = `TMIRQ_RST8;
    ack_main[`TMIRQ_BIT_T1_OVF] = vector_ack.t1_ovf;
    ack_main[`TMIRQ_BIT_T1_CMPA] = vector_ack.t1_cmpa;
    ack_main[`TMIRQ_BIT_T1_CMPB] = vector_ack.t1_cmpb;
    ack_main[`TMIRQ_BIT_T1_CAP] = vector_ack.t1_cap;
    ack_ext[`TMIRQ_BIT_T3_CAP] = vector_ack.t3_cap;
    ack_ext[`TMIRQ_BIT_T3_CMPA] = vector_ack.t3_cmpa;
    ack_ext[`TMIRQ_BIT_T3_CMPB] = vector_ack.t3_cmpb;
    ack_ext[`TMIRQ_BIT_T3_OVF] = vector_ack.t3_ovf;
  end

  // ===========================================================================
  // ahb-lite address phase capture
  assign addr_ok = hsel && hready && (htrans == `TMIRQ_HTRANS_NONSEQ ||
                   htrans == `TMIRQ_HTRANS_SEQ);
  assign rd_take = addr_ok && !hwrite;
  assign addr_idx = haddr[`TMIRQ_ADDR_MSB:`TMIRQ_ADDR_LSB];

  // a write waits one cycle for its data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_pend_q <= 1'b0;
    else
      wr_pend_q <= addr_ok && hwrite;
  end

  // register index held for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_idx_q <= '0;
    else if (addr_ok)
      wr_idx_q <= addr_idx;
  end

  // register selects of the write data phase
  assign wr_mask = wr_pend_q && ({wr_idx_q, 2'b00} == `TMIRQ_OFS_MASK);
  assign wr_ext_mask = wr_pend_q && ({wr_idx_q, 2'b00} == `TMIRQ_OFS_EXT_MASK);
  assign wr_flags = wr_pend_q && ({wr_idx_q, 2'b00} == `TMIRQ_OFS_FLAGS);
  assign wr_ext_flags = wr_pend_q && ({wr_idx_q, 2'b00} == `TMIRQ_OFS_EXT_FLAGS);
  assign wr_status = wr_pend_q && ({wr_idx_q, 2'b00} == `TMIRQ_OFS_IRQ_STATUS);
  assign wr_irq_mask = wr_pend_q && ({wr_idx_q, 2'b00} == `TMIRQ_OFS_IRQ_MASK);

  // slave always ready, no wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else
      hreadyout <= 1'b1;
  end

  // response always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // write-one-to-clear strobes from the data phase
  always_comb
  begin
    wdat = hwdata[7:0];
    w1c_main = `TMIRQ_RST8;
    w1c_ext = `TMIRQ_RST8;
    w1c_stat = `TMIRQ_RST8;
    if (wr_flags)
      w1c_main = wdat & `TMIRQ_T1_BITS;
    if (wr_ext_flags)
      w1c_ext = wdat & `TMIRQ_T3_BITS;
    if (wr_status)
      w1c_stat = wdat;
  end

  // ===========================================================================
  // mask registers
  // timer 1 enables, unused bits stay zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_irq_mask_q <= `TMIRQ_RST8;
    else if (wr_mask)
      timer_irq_mask_q <= wdat & `TMIRQ_T1_BITS;
  end

  // timer 3 enables, unused bits stay zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_timer_irq_mask_q <= `TMIRQ_RST8;
    else if (wr_ext_mask)
      ext_timer_irq_mask_q <= wdat & `TMIRQ_T3_BITS;
  end

  // summary interrupt mask, all bits writable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_mask_q <= `TMIRQ_RST8;
    else if (wr_irq_mask)
      irq_mask_q <= wdat;
  end

  // next flags: set wins over vector ack and write-one clear
  assign flags_d = (timer_irq_flags_q & ~(w1c_main | ack_main)) | set_main;
  assign ext_flags_d = (ext_timer_irq_flags_q & ~(w1c_ext | ack_ext)) | set_ext;

  // timer 1 flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_irq_flags_q <= `TMIRQ_RST8;
    else
      timer_irq_flags_q <= flags_d;
  end

  // timer 3 flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ext_timer_irq_flags_q <= `TMIRQ_RST8;
    else
      ext_timer_irq_flags_q <= ext_flags_d;
  end

  // ===========================================================================
  // per-source requests gated by enable, global enable and flag
  // timer 1 sources
  always_comb
  begin
    req_d.t1_ovf = global_irq_en && timer_irq_mask_q[`TMIRQ_BIT_T1_OVF] &&
                   timer_irq_flags_q[`TMIRQ_BIT_T1_OVF];
    req_d.t1_cmpa = global_irq_en && timer_irq_mask_q[`TMIRQ_BIT_T1_CMPA] &&
                    timer_irq_flags_q[`TMIRQ_BIT_T1_CMPA];
    req_d.t1_cmpb = global_irq_en && timer_irq_mask_q[`TMIRQ_BIT_T1_CMPB] &&
                    timer_irq_flags_q[`TMIRQ_BIT_T1_CMPB];
    req_d.t1_cap = global_irq_en && timer_irq_mask_q[`TMIRQ_BIT_T1_CAP] &&
                   timer_irq_flags_q[`TMIRQ_BIT_T1_CAP];
  end

  // timer 3 sources
  always_comb
  begin
    req_d.t3_cap = global_irq_en && ext_timer_irq_mask_q[`TMIRQ_BIT_T3_CAP] &&
                   ext_timer_irq_flags_q[`TMIRQ_BIT_T3_CAP];
    req_d.t3_cmpa = global_irq_en && ext_timer_irq_mask_q[`TMIRQ_BIT_T3_CMPA] &&
                    ext_timer_irq_flags_q[`TMIRQ_BIT_T3_CMPA];
    req_d.t3_cmpb = global_irq_en && ext_timer_irq_mask_q[`TMIRQ_BIT_T3_CMPB] &&
                    ext_timer_irq_flags_q[`TMIRQ_BIT_T3_CMPB];
    req_d.t3_ovf = global_irq_en && ext_timer_irq_mask_q[`TMIRQ_BIT_T3_OVF] &&
                   ext_timer_irq_flags_q[`TMIRQ_BIT_T3_OVF];
  end

  // registered requests to the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_req <= '0;
    else
      irq_req <= req_d;
  end

  // ===========================================================================
  // sticky summary status, one bit per source in request order
  assign new_events = {set_main[`TMIRQ_BIT_T1_OVF], set_main[`TMIRQ_BIT_T1_CMPA],
                       set_main[`TMIRQ_BIT_T1_CMPB], set_main[`TMIRQ_BIT_T1_CAP],
                       set_ext[`TMIRQ_BIT_T3_CAP], set_ext[`TMIRQ_BIT_T3_CMPA],
                       set_ext[`TMIRQ_BIT_T3_CMPB], set_ext[`TMIRQ_BIT_T3_OVF]};

  // next status and level, a new event wins over the clear
  assign status_d = (irq_status_q & ~w1c_stat) | new_events;
  assign irq_d = |(status_d & irq_mask_q);

  // sticky status register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_status_q <= `TMIRQ_RST8;
    else
      irq_status_q <= status_d;
  end

  // summary interrupt level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= irq_d;
  end

  // ===========================================================================
  // read data, decoded in the address phase cycle
  always_comb
  begin
    rd_val = `TMIRQ_RST8;
    unique case ({addr_idx, 2'b00})
      `TMIRQ_OFS_MASK: rd_val = timer_irq_mask_q;
      `TMIRQ_OFS_EXT_MASK: rd_val = ext_timer_irq_mask_q;
      `TMIRQ_OFS_FLAGS: rd_val = timer_irq_flags_q;
      `TMIRQ_OFS_EXT_FLAGS: rd_val = ext_timer_irq_flags_q;
      `TMIRQ_OFS_GLOBAL: rd_val = {7'h00, global_irq_en};
      `TMIRQ_OFS_IRQ_STATUS: rd_val = irq_status_q;
      `TMIRQ_OFS_IRQ_MASK: rd_val = irq_mask_q;
      default: rd_val = `TMIRQ_RST8;
    endcase
  end

  // read word captured at the address phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= `TMIRQ_RST32;
    else if (rd_take)
      hrdata <= {24'h000000, rd_val};
  end
endmodule

/* File: tb/tmirq_monitor.sv */
// assertion checker for the timer interrupt block ports
`timescale 1ns/100ps
module tmirq_monitor
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // timer events and core side
  input wire tmirq_pkg::tmirq_timer_ev_t t1_ev,
  input wire logic global_irq_en,
  input wire tmirq_pkg::tmirq_src_t vector_ack,
  input wire tmirq_pkg::tmirq_src_t irq_req
);
  import tmirq_pkg::*;
  logic wr_q;
  logic [7:0] a_q;
  logic [7:0] m_q;
  logic [7:0] e_q;
  // shadow of the timer 1 and timer 3 mask registers, snooped from bus writes
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      a_q <= 8'h00;
      m_q <= 8'h00;
      e_q <= 8'h00;
    end
    else if (hready)
    begin
      wr_q <= hsel && htrans[1] && hwrite;
      a_q <= haddr[7:0];
      if (wr_q && a_q == 8'h00)
        m_q <= hwdata[7:0];
      if (wr_q && a_q == 8'h04)
        e_q <= hwdata[7:0];
    end
  // =====================================================
  // port checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered with an error");
  a_req_global: assert property (|irq_req |-> $past(global_irq_en))
    else $error("request without global enable");
  a_t1ovf_mask: assert property (irq_req.t1_ovf |-> $past(m_q[7]))
    else $error("t1 overflow request while disabled");
  a_t1cmpb_mask: assert property (irq_req.t1_cmpb |-> $past(m_q[5]))
    else $error("t1 compare b request while disabled");
  a_t3cap_mask: assert property (irq_req.t3_cap |-> $past(e_q[5]))
    else $error("t3 capture request while disabled");
  a_t3ovf_mask: assert property (irq_req.t3_ovf |-> $past(e_q[2]))
    else $error("t3 overflow request while disabled");
  a_ack_clears: assert property (vector_ack.t1_ovf && !t1_ev.overflow && !$past(t1_ev.overflow)
    && !$past(t1_ev.overflow, 2) |-> ##2 !irq_req.t1_ovf)
    else $error("vector did not clear the overflow request");
  a_cmpa_late: assert property (t1_ev.match_a && m_q[6] && global_irq_en ##1 (global_irq_en
    && vector_ack == 8'h00 && !(hsel && htrans[1] && hwrite))[*4] |-> irq_req.t1_cmpa)
    else $error("compare a request missing after match");
endmodule
bind tmirq_top tmirq_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .t1_ev, .global_irq_en, .vector_ack, .irq_req);

/* File: tb/tmirq_cpu_model.sv */
// model of the cpu core that runs timer interrupt vectors
`timescale 1ns/100ps
module tmirq_cpu_model
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench control
  input wire logic ack_en,
  input wire logic [3:0] lat,
  // requests and vector acknowledge
  input wire tmirq_pkg::tmirq_src_t irq_req,
  output tmirq_pkg::tmirq_src_t vector_ack
);
  import tmirq_pkg::*;
  logic [3:0] wait_q;
  // run the lowest pending vector after lat cycles, lat of 2 or more
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wait_q <= 4'h0;
      vector_ack <= '0;
    end
    else if (ack_en && irq_req != 8'h00 && wait_q == lat)
    begin
      vector_ack <= irq_req & (~irq_req + 8'h01);
      wait_q <= 4'h0;
    end
    else
    begin
      vector_ack <= '0;
      wait_q <= (irq_req != 8'h00) ? wait_q + 4'h1 : 4'h0;
    end
endmodule

/* File: tb/timer16_irq_mask_flags_bench.sv */
// self-checking bench for the timer interrupt block
`timescale 1ns/100ps
module timer16_irq_mask_flags_bench;
  import tmirq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0, hreadyout, hresp, irq, ack_en = 1'b0, glob = 1'b0;
  logic [3:0] lat = 4'h2;
  logic [7:0] r;
  tmirq_timer_ev_t t1_ev = '0, t3_ev = '0;
  tmirq_src_t vector_ack, irq_req;
  int error_cnt = 0, samples_checked = 0, seed = 32'h52d144b0, i, k, m, g;
  byte evb[8] = '{7, 6, 5, 4, 4, 6, 5, 7};
  byte fbit[8] = '{7, 6, 5, 3, 5, 4, 3, 2};
  // clock
  always #5 hclk = ~hclk;
  tmirq_top dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .t1_ev, .t3_ev,
    .global_irq_en(glob), .vector_ack, .irq_req, .irq);
  tmirq_cpu_model cpu (.hclk, .hresetn, .ack_en, .lat, .irq_req, .vector_ack);
  // event strobes and flag pattern of one source
  function automatic logic [15:0] evs(int s);
    return s < 4 ? {8'h1 << evb[s], 8'h0} : {8'h0, 8'h1 << evb[s]};
  endfunction
  function automatic logic [31:0] fexp(int s);
    return 32'h1 << fbit[s];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single ahb-lite transfer, waiting on ready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(d, e);
  endtask
  // one-cycle event pulse, keeping the top level, then settle
  task automatic pulse(input logic [15:0] v);
    @(posedge hclk);
    t1_ev <= t1_ev | v[15:8];
    t3_ev <= t3_ev | v[7:0];
    @(posedge hclk);
    t1_ev <= t1_ev & 8'h04;
    t3_ev <= t3_ev & 8'h04;
    repeat (6) @(posedge hclk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #300000;
    error_cnt++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 8; i++)
      rd(8'(i * 4), 32'h0);
    wr(8'h00, 32'hff);
    rd(8'h00, 32'he8);
    wr(8'h04, 32'hff);
    rd(8'h04, 32'h3c);
    wr(8'h1c, 32'hff);
    rd(8'h1c, 32'h0);
    wr(8'h08, 32'hff);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    glob <= 1'b1;
    rd(8'h10, 32'h1);
    for (i = 0; i < 8; i++)
    begin
      r = (i < 4) ? 8'h00 : 8'h04;
      wr(r, fexp(i));
      pulse(evs(i));
      rd(r + 8'h08, fexp(i));
      chk({24'h0, irq_req}, 32'h80 >> i);
      wr(r + 8'h08, ~fexp(i));
      rd(r + 8'h08, fexp(i));
      wr(r + 8'h08, fexp(i));
      rd(r + 8'h08, 32'h0);
      wr(r, 32'h0);
    end
    pulse(16'h0303);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    t1_ev <= 8'h04;
    t3_ev <= 8'h04;
    pulse(16'h1010);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    pulse(16'h0808);
    rd(8'h08, 32'h08);
    rd(8'h0c, 32'h20);
    t1_ev <= 8'h00;
    t3_ev <= 8'h00;
    wr(8'h08, 32'hff);
    wr(8'h0c, 32'hff);
    for (i = 0; i < 24; i++)
    begin
      k = $random(seed) & 7;
      m = $random(seed) & 1;
      g = $random(seed) & 1;
      r = (k < 4) ? 8'h00 : 8'h04;
      glob <= g[0];
      wr(r, m ? fexp(k) : 32'h0);
      pulse(evs(k));
      chk({24'h0, irq_req}, (m & g) ? 32'h80 >> k : 32'h0);
      wr(r + 8'h08, fexp(k));
      wr(r, 32'h0);
    end
    glob <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      k = i ? 0 : 4;
      r = (k < 4) ? 8'h00 : 8'h04;
      lat <= i ? 4'h5 : 4'h2;
      ack_en <= 1'b1;
      wr(r, fexp(k));
      pulse(evs(k));
      repeat (10) @(posedge hclk);
      rd(r + 8'h08, 32'h0);
      ack_en <= 1'b0;
      wr(r, 32'h0);
    end
    wr(8'h14, 32'hff);
    wr(8'h18, 32'h01);
    rd(8'h18, 32'h01);
    pulse(evs(7));
    chk({31'h0, irq}, 32'h1);
    rd(8'h14, 32'h01);
    wr(8'h18, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule
